// ---- verilog/flash_iap_pkg.sv ----
// Shared constants for the in-application flash write controller.
package flash_iap_pkg;
    localparam logic [7:0] SFR_SOFT_CMD = 8'h97;
    localparam logic [7:0] SFR_WE_KEY = 8'hC9;
    localparam logic [7:0] SFR_BANDGAP = 8'hF5;
    localparam logic [7:0] SFR_CFG_LOW = 8'hF6;
    localparam logic [7:0] SFR_AUX_TWO = 8'hF7;
    localparam logic [7:0] KEY_UNLOCK = 8'h65;
    localparam logic [7:0] KEY_FLASH_WE = 8'h47;
    localparam logic [7:0] KEY_EEPROM_WE = 8'hE2;
    localparam logic [15:0] ADDR_LAST = 16'h1FFF;
    localparam logic [15:0] ADDR_FREE_LO = 16'h1F00;
    localparam logic [15:0] ADDR_FREE_HI = 16'h1FEF;
    localparam logic [15:0] ADDR_CFG_LO = 16'h1FF0;
    localparam logic [15:0] ADDR_CFG_HIGH_WORD = 16'h1FFF;
    localparam logic [15:0] ADDR_BANDGAP = 16'h1FFB;
    localparam logic [15:0] ADDR_CFG_LOW = 16'h1FFD;
    localparam logic [15:0] ADDR_EE_LO = 16'hEE00;
    localparam logic [15:0] ADDR_EE_HI = 16'hEEFE;
    localparam int WE_FLASH_BIT = 7;
    localparam int WE_TIMEOUT_BIT = 6;
    localparam int WE_EEPROM_BIT = 5;
    localparam int TSEL_LSB = 1;
    localparam logic [7:0] AUX_TWO_RESET = 8'h06;
    localparam int CLK_KHZ = 125000;
    localparam int WRITE_US = 500;
    localparam int EE_WRITE_US = 1000;
    localparam int TO1_US = 1600;
    localparam int TO2_US = 3200;
    localparam int TO3_US = 12800;
    localparam int WRITE_CYC = WRITE_US * CLK_KHZ / 1000;
    localparam int EE_WRITE_CYC = EE_WRITE_US * CLK_KHZ / 1000;
    localparam int TO1_CYC = TO1_US * CLK_KHZ / 1000;
    localparam int TO2_CYC = TO2_US * CLK_KHZ / 1000;
    localparam int TO3_CYC = TO3_US * CLK_KHZ / 1000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_DONE = 2'b11,
        ST_LOAD = 2'b10
    } state_t;
endpackage : flash_iap_pkg

// ---- verilog/flash_iap_ctrl.sv ----
// In-application flash write controller with region protection and timeout.
// What this block does
// - Flash space spans 0000h to 1FFFh in vector, code, free, config sectors.
// - Top sixteen bytes hold configuration; bandgap byte and low word load into registers at power-on.
// - Free data sector 1F00h-1FEFh needs no unlock; only the flash write flag gates it.
// - Each write programs one byte with no page erase first.
// - Writing 65h to soft command register sets full-range unlock.
// - Writing any other value there clears full-range unlock.
// - With unlock set, writes from address zero up to 1FFEh are accepted.
// - High config word never reachable; low word and bandgap only when unlocked.
// - Power-on copies low config word and bandgap byte into F6h and F5h.
// - A write is a data-move store of accumulator to data pointer address.
// - Flash writes are ignored unless flash write flag is set.
// - CPU waits about half a millisecond per flash byte, a millisecond per eeprom byte; peripherals keep running.
// - Code-move reads complete with no extra wait cycles.
// - Key 47h sets flash flag, E2h eeprom flag, others clear both.
// - Bit seven of the key register reads one while flash writes enabled.
// - Soft command bit zero reads one after 65h, zero after 00h.
// - A write timeout releases the CPU from a stalled or failed write.
// - Two-bit select: zero disables timeout, else 1.6, 3.2 or 12.8 ms.
`timescale 1ns/1ps
module flash_iap_ctrl #(
    parameter int WRITE_CYCLES = flash_iap_pkg::WRITE_CYC,
    parameter int EE_WRITE_CYCLES = flash_iap_pkg::EE_WRITE_CYC,
    parameter int TO1_CYCLES = flash_iap_pkg::TO1_CYC,
    parameter int TO2_CYCLES = flash_iap_pkg::TO2_CYC,
    parameter int TO3_CYCLES = flash_iap_pkg::TO3_CYC
) (
    input wire logic clock_i, // System clock.
    input wire logic nrst_i, // Power-on reset, active low.
    input wire logic clk_en_i, // Freezes all state except the reset synchroniser while low.
    input wire logic sfr_wr_i, // Special register write strobe.
    input wire logic sfr_rd_i, // Special register read strobe.
    input wire logic [7:0] sfr_addr_i, // Special register address.
    input wire logic [7:0] sfr_wdata_i, // Special register write data.
    input wire logic xmove_wr_i, // External-data-move store strobe.
    input wire logic [15:0] dptr_i, // Data pointer target address.
    input wire logic [7:0] acc_i, // Accumulator data to write.
    input wire logic [15:0] code_addr_i, // Code-move read address.
    input wire logic [7:0] flash_rdata_i, // Array read data for the current address.
    input wire logic flash_done_i, // Array reports the byte is programmed.
    output logic [7:0] sfr_rdata_o, // Special register read data.
    output logic cpu_wait_o, // Holds the CPU while a write runs.
    output logic [15:0] flash_addr_o, // Array address.
    output logic [7:0] flash_wdata_o, // Array byte to program.
    output logic flash_prog_o, // Array byte program in progress.
    output logic ee_prog_o, // Eeprom byte program in progress.
    output logic [7:0] cfg_low_o, // Low configuration register.
    output logic [7:0] bandgap_o, // Bandgap trim register.
    output logic [7:0] aux_two_o // Auxiliary control two register.
);
    typedef struct packed {
        logic [1:0] rst_sync;
        flash_iap_pkg::state_t state;
        logic [1:0] load_idx;
        logic full_range_unlock;
        logic flash_write_flag;
        logic eeprom_write_flag;
        logic write_timeout_flag;
        logic is_ee;
        logic [23:0] prog_cnt;
        logic [23:0] to_cnt;
        logic [7:0] rdata;
        logic wait_q;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic fprog;
        logic eprog;
        logic [7:0] cfg_low;
        logic [7:0] bandgap;
        logic [7:0] aux_two;
    } state_all_t;

    // One flag per mapped special register; reads and writes decode alike.
    typedef struct packed {
        logic soft_cmd;
        logic we_key;
        logic bandgap;
        logic cfg_low;
        logic aux_two;
    } sfr_sel_t;

    state_all_t s_q;
    state_all_t s_d;
    logic rst_n;
    logic fl_ok;
    logic ee_ok;
    logic [23:0] to_limit;
    logic start_fl;
    logic start_ee;
    logic prog_end;
    logic to_end;
    sfr_sel_t sel;

    // Only the synchroniser moves until its second stage is high, so release is clean.
    assign rst_n = s_q.rst_sync[1];

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic sfr_sel_t sfr_decode(input logic [7:0] a);
        sfr_decode = '0;
        if (a == flash_iap_pkg::SFR_SOFT_CMD)
        begin
            sfr_decode.soft_cmd = 1'b1;
        end
        else if (a == flash_iap_pkg::SFR_WE_KEY)
        begin
            sfr_decode.we_key = 1'b1;
        end
        else if (a == flash_iap_pkg::SFR_BANDGAP)
        begin
            sfr_decode.bandgap = 1'b1;
        end
        else if (a == flash_iap_pkg::SFR_CFG_LOW)
        begin
            sfr_decode.cfg_low = 1'b1;
        end
        else if (a == flash_iap_pkg::SFR_AUX_TWO)
        begin
            sfr_decode.aux_two = 1'b1;
        end
    endfunction : sfr_decode

    assign sel = sfr_decode(sfr_addr_i);

    // Region check for a flash store; the high word is never writable.
    always_comb
    begin
        fl_ok = 1'b0;
        if (dptr_i > flash_iap_pkg::ADDR_LAST)
        begin
            fl_ok = 1'b0;
        end
        else if (dptr_i == flash_iap_pkg::ADDR_CFG_HIGH_WORD)
        begin
            fl_ok = 1'b0;
        end
        else if (in_range(dptr_i, flash_iap_pkg::ADDR_FREE_LO, flash_iap_pkg::ADDR_FREE_HI))
        begin
            fl_ok = 1'b1;
        end
        else
        begin
            fl_ok = s_q.full_range_unlock;
        end
        // Eeprom cells sit at even addresses only; an odd target is refused.
        ee_ok = in_range(dptr_i, flash_iap_pkg::ADDR_EE_LO, flash_iap_pkg::ADDR_EE_HI)
            && !dptr_i[0];
    end

    always_comb
    begin
        case (s_q.aux_two[flash_iap_pkg::TSEL_LSB +: 2])
            2'b01: to_limit = 24'(TO1_CYCLES);
            2'b10: to_limit = 24'(TO2_CYCLES);
            2'b11: to_limit = 24'(TO3_CYCLES);
            default: to_limit = 24'h00_0000;
        endcase
    end

    // A store is taken only from idle, so a store during a stall cannot restart it.
    always_comb
    begin
        start_fl = (s_q.state == flash_iap_pkg::ST_IDLE) && xmove_wr_i
            && s_q.flash_write_flag && fl_ok;
        start_ee = (s_q.state == flash_iap_pkg::ST_IDLE) && xmove_wr_i
            && s_q.eeprom_write_flag && ee_ok && !start_fl;
        // The nominal time is a floor: a slow array stretches the write until it is done.
        prog_end = flash_done_i && (s_q.prog_cnt >= 24'(s_q.is_ee ? EE_WRITE_CYCLES
            : WRITE_CYCLES) - 24'd1);
        to_end = (to_limit != 24'h00_0000) && (s_q.to_cnt >= to_limit - 24'd1);
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        // Timeout flag follows the enable flags down.
        if (!s_q.flash_write_flag && !s_q.eeprom_write_flag)
        begin
            s_d.write_timeout_flag = 1'b0;
        end
        // Register reads; code-move reads bypass this block entirely.
        s_d.rdata = 8'h00;
        // A read answers one cycle later and shows zero otherwise, so no stale byte lingers.
        if (sfr_rd_i)
        begin
            if (sel.soft_cmd)
            begin
                s_d.rdata = {7'h00, s_q.full_range_unlock};
            end
            else if (sel.we_key)
            begin
                s_d.rdata[flash_iap_pkg::WE_FLASH_BIT] = s_q.flash_write_flag;
                s_d.rdata[flash_iap_pkg::WE_TIMEOUT_BIT] = s_q.write_timeout_flag;
                s_d.rdata[flash_iap_pkg::WE_EEPROM_BIT] = s_q.eeprom_write_flag;
            end
            else if (sel.bandgap)
            begin
                s_d.rdata = s_q.bandgap;
            end
            else if (sel.cfg_low)
            begin
                s_d.rdata = s_q.cfg_low;
            end
            else if (sel.aux_two)
            begin
                s_d.rdata = s_q.aux_two;
            end
        end
        if (sfr_wr_i)
        begin
            if (sel.soft_cmd)
            begin
                s_d.full_range_unlock = (sfr_wdata_i == flash_iap_pkg::KEY_UNLOCK);
            end
            else if (sel.we_key)
            begin
                s_d.flash_write_flag = (sfr_wdata_i == flash_iap_pkg::KEY_FLASH_WE);
                s_d.eeprom_write_flag = (sfr_wdata_i == flash_iap_pkg::KEY_EEPROM_WE);
            end
            else if (sel.bandgap)
            begin
                s_d.bandgap = sfr_wdata_i;
            end
            else if (sel.cfg_low)
            begin
                s_d.cfg_low = sfr_wdata_i;
            end
            else if (sel.aux_two)
            begin
                s_d.aux_two = sfr_wdata_i;
            end
        end
        case (s_q.state)
            flash_iap_pkg::ST_LOAD:
            begin
                // Copy bandgap byte, then low word, out of the array once after reset.
                // The array read is combinational, so each byte is taken while its address stands.
                s_d.load_idx = s_q.load_idx + 2'd1;
                s_d.addr = flash_iap_pkg::ADDR_CFG_LOW;
                if (s_q.load_idx == 2'd0)
                begin
                    s_d.bandgap = flash_rdata_i;
                end
                else
                begin
                    s_d.cfg_low = flash_rdata_i;
                    s_d.state = flash_iap_pkg::ST_IDLE;
                end
            end
            flash_iap_pkg::ST_IDLE:
            begin
                s_d.addr = code_addr_i;
                if (start_fl)
                begin
                    s_d.state = flash_iap_pkg::ST_PROG;
                    s_d.is_ee = 1'b0;
                    s_d.addr = dptr_i;
                    s_d.wdata = acc_i;
                    s_d.fprog = 1'b1;
                    s_d.wait_q = 1'b1;
                    s_d.prog_cnt = 24'h00_0000;
                    s_d.to_cnt = 24'h00_0000;
                end
                else if (start_ee)
                begin
                    s_d.state = flash_iap_pkg::ST_PROG;
                    s_d.is_ee = 1'b1;
                    s_d.addr = dptr_i;
                    s_d.wdata = acc_i;
                    s_d.eprog = 1'b1;
                    s_d.wait_q = 1'b1;
                    s_d.prog_cnt = 24'h00_0000;
                    s_d.to_cnt = 24'h00_0000;
                end
            end
            flash_iap_pkg::ST_PROG:
            begin
                s_d.prog_cnt = s_q.prog_cnt + 24'd1;
                s_d.to_cnt = s_q.to_cnt + 24'd1;
                if (prog_end)
                begin
                    s_d.state = flash_iap_pkg::ST_DONE;
                end
                else if (to_end)
                begin
                    // The set follows the clear above, so a timeout is never lost to it.
                    s_d.write_timeout_flag = 1'b1;
                    s_d.state = flash_iap_pkg::ST_DONE;
                end
            end
            flash_iap_pkg::ST_DONE:
            begin
                // The strobe stands one more edge so the array sees a settled end of write.
                s_d.fprog = 1'b0;
                s_d.eprog = 1'b0;
                s_d.wait_q = 1'b0;
                s_d.state = flash_iap_pkg::ST_IDLE;
            end
            default:
            begin
                s_d.state = flash_iap_pkg::ST_IDLE;
            end
        endcase
    end

    // Reset loads only constants; the configuration copy is taken later by the load state.
    // The synchroniser is not gated by the clock enable, so a frozen clock cannot hold reset.
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
            s_q.state <= flash_iap_pkg::ST_LOAD;
            s_q.addr <= flash_iap_pkg::ADDR_BANDGAP;
            s_q.aux_two <= flash_iap_pkg::AUX_TWO_RESET;
        end
        else if (!rst_n)
        begin
            s_q.rst_sync <= s_d.rst_sync;
        end
        else if (clk_en_i)
        begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_o = s_q.rdata;
    assign cpu_wait_o = s_q.wait_q;
    assign flash_addr_o = s_q.addr;
    assign flash_wdata_o = s_q.wdata;
    assign flash_prog_o = s_q.fprog;
    assign ee_prog_o = s_q.eprog;
    assign cfg_low_o = s_q.cfg_low;
    assign bandgap_o = s_q.bandgap;
    assign aux_two_o = s_q.aux_two;
endmodule : flash_iap_ctrl

// ---- test/flash_array_model.sv ----
// Behavioural flash array with immediate reads and a programmable program latency.
`timescale 1ns/1ps
module flash_array_model (
    input wire logic clock_i, // System clock.
    input wire logic [15:0] addr_i, // Array address.
    input wire logic [7:0] wdata_i, // Byte to program.
    input wire logic prog_i, // Program in progress.
    input wire logic [7:0] lat_i, // Cycles to done; FFh never finishes.
    output logic [7:0] rdata_o, // Read data.
    output logic done_o // Byte programmed.
);
    logic [7:0] mem [0:8191];
    logic [7:0] cnt_q = 8'h00;
    initial
    begin
        for (int i = 0; i < 8192; i++)
        begin
            mem[i] = 8'(i * 7 + 3);
        end
    end
    assign rdata_o = mem[addr_i[12:0]];
    assign done_o = (cnt_q >= lat_i) && (lat_i != 8'hFF);
    always @(posedge clock_i)
    begin
        cnt_q <= prog_i ? cnt_q + 8'h01 : 8'h00;
        // A failed write never reaches the cells, so the old byte must survive.
        if (prog_i && done_o)
        begin
            mem[addr_i[12:0]] <= wdata_i;
        end
    end
endmodule : flash_array_model

// ---- test/flash_iap_monitor.sv ----
// Port-level assertions for the flash write controller.
`timescale 1ns/1ps
module flash_iap_monitor #(
    parameter int WRITE_CYCLES = flash_iap_pkg::WRITE_CYC
) (
    input wire logic clock_i, // Clock.
    input wire logic nrst_i, // Reset.
    input wire logic clk_en_i, // Enable.
    input wire logic sfr_wr_i, // Write.
    input wire logic sfr_rd_i, // Read.
    input wire logic [7:0] sfr_addr_i, // Address.
    input wire logic [7:0] sfr_wdata_i, // Data.
    input wire logic xmove_wr_i, // Store.
    input wire logic [15:0] dptr_i, // Target.
    input wire logic [7:0] acc_i, // Byte.
    input wire logic [15:0] code_addr_i, // Code address.
    input wire logic [7:0] flash_rdata_i, // Array data.
    input wire logic flash_done_i, // Array done.
    input wire logic [7:0] sfr_rdata_o, // Read data.
    input wire logic cpu_wait_o, // Stall.
    input wire logic [15:0] flash_addr_o, // Array address.
    input wire logic [7:0] flash_wdata_o, // Array byte.
    input wire logic flash_prog_o, // Flash program.
    input wire logic ee_prog_o, // Eeprom program.
    input wire logic [7:0] cfg_low_o, // Config low.
    input wire logic [7:0] bandgap_o, // Bandgap.
    input wire logic [7:0] aux_two_o // Aux two.
);
    logic fl_q;
    logic [23:0] cnt_q;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            fl_q <= 1'b0;
            cnt_q <= 24'h00_0000;
        end
        else
        begin
            if (sfr_wr_i && clk_en_i && sfr_addr_i == 8'hC9)
            begin
                fl_q <= (sfr_wdata_i == 8'h47);
            end
            cnt_q <= flash_prog_o ? cnt_q + 24'h00_0001 : 24'h00_0000;
        end
    end
    sequence key_wr(logic [7:0] a, logic [7:0] d);
        sfr_wr_i && clk_en_i && sfr_addr_i == a && sfr_wdata_i == d;
    endsequence
    sequence reg_rd(logic [7:0] a);
        sfr_rd_i && clk_en_i && sfr_addr_i == a;
    endsequence
    chk_unlock_read: assert property (key_wr(8'h97, 8'h65) ##2 reg_rd(8'h97) |=> sfr_rdata_o == 8'h01)
        else $error("unlock bit not read back");
    chk_flash_key: assert property (key_wr(8'hC9, 8'h47) ##2 reg_rd(8'hC9) |=> sfr_rdata_o[7])
        else $error("flash write flag not set by key");
    chk_key_clear: assert property (sfr_wr_i && clk_en_i && sfr_addr_i == 8'hC9 && sfr_wdata_i != 8'h47
        && sfr_wdata_i != 8'hE2 ##2 reg_rd(8'hC9) |=> sfr_rdata_o == 8'h00) else $error("flags not cleared");
    chk_unmapped_zero: assert property (sfr_rd_i && clk_en_i
        && !(sfr_addr_i inside {8'h97, 8'hC9, 8'hF5, 8'hF6, 8'hF7}) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_wait_cover: assert property (flash_prog_o || ee_prog_o |-> cpu_wait_o)
        else $error("program without stall");
    chk_refused_idle: assert property (xmove_wr_i && clk_en_i && !cpu_wait_o && (dptr_i == 16'h1FFF
        || !fl_q && dptr_i < 16'hE000) |=> !cpu_wait_o && !flash_prog_o && !ee_prog_o)
        else $error("refused write stalled");
    chk_accept_latch: assert property (xmove_wr_i && clk_en_i && !cpu_wait_o && fl_q
        && dptr_i inside {[16'h1F00:16'h1FEF]} |=> cpu_wait_o && flash_prog_o
        && flash_addr_o == $past(dptr_i) && flash_wdata_o == $past(acc_i)) else $error("write not taken");
    chk_prog_length: assert property ($fell(flash_prog_o) |-> cnt_q >= WRITE_CYCLES)
        else $error("program ended early");
endmodule : flash_iap_monitor
bind flash_iap_ctrl flash_iap_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_flash_iap_monitor (.*);

// ---- test/testbench.sv ----
// Directed testbench for the in-application flash write controller.
`timescale 1ns/1ps
module testbench;
    localparam int W = 20, E = 40, T1 = 30, T2 = 60, T3 = 200;
    logic clock_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, rd = 1'b0, xw = 1'b0, cw, fp, ep, fdn;
    logic [7:0] sa = 8'h00, sd = 8'h00, acc = 8'h00, lat = 8'h00, rdat, frd, cfl, bg, aux, fwd;
    logic [15:0] dptr = 16'h0000, ca = 16'h0000, fa;
    int err_count = 0, compares = 0, n;
    always #4 clock_i = ~clock_i;
    flash_iap_ctrl #(.WRITE_CYCLES(W), .EE_WRITE_CYCLES(E), .TO1_CYCLES(T1), .TO2_CYCLES(T2),
        .TO3_CYCLES(T3)) u_flash_iap_ctrl (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(sa), .sfr_wdata_i(sd), .xmove_wr_i(xw),
        .dptr_i(dptr), .acc_i(acc), .code_addr_i(ca), .flash_rdata_i(frd), .flash_done_i(fdn),
        .sfr_rdata_o(rdat), .cpu_wait_o(cw), .flash_addr_o(fa), .flash_wdata_o(fwd),
        .flash_prog_o(fp), .ee_prog_o(ep), .cfg_low_o(cfl), .bandgap_o(bg), .aux_two_o(aux));
    flash_array_model u_flash_array_model (.clock_i(clock_i), .addr_i(fa), .wdata_i(fwd),
        .prog_i(fp), .lat_i(lat), .rdata_o(frd), .done_o(fdn));
    function automatic logic [7:0] init(input logic [15:0] a);
        return 8'(a * 7 + 3);
    endfunction : init
    task automatic end_of_test;
        if (err_count == 0 && compares > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {wr, sa, sd} = {1'b1, a, d};
        @(negedge clock_i);
        wr = 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_i);
        {rd, sa} = {1'b1, a};
        @(negedge clock_i);
        rd = 1'b0;
        check("sfr read", {8'h00, rdat}, {8'h00, e});
    endtask : sfr_rd
    // A zero stall figure means the store must be refused outright.
    task automatic xchk(input logic [15:0] a, input logic [7:0] d, input int lo);
        @(negedge clock_i);
        {xw, dptr, acc} = {1'b1, a, d};
        @(negedge clock_i);
        xw = 1'b0;
        if (lo != 0)
        begin
            check("prog addr", fa, a);
            check("prog data", {8'h00, fwd}, {8'h00, d});
            check("kind", {14'h0000, ep, fp}, (a >= 16'hEE00) ? 16'h0002 : 16'h0001);
        end
        else
        begin
            check("refused strobe", {14'h0000, ep, fp}, 16'h0000);
        end
        n = 0;
        while (cw === 1'b1 && n < 1000)
        begin
            @(negedge clock_i);
            n++;
        end
        check("stall", 16'((lo == 0) ? (n == 0) : (n >= lo && n <= lo + 8)), 16'h0001);
    endtask : xchk
    task automatic crd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clock_i);
        ca = a;
        @(negedge clock_i);
        check("code addr", fa, a);
        check("code data", {8'h00, frd}, {8'h00, e});
        check("code wait", {15'h0000, cw}, 16'h0000);
    endtask : crd
    initial
    begin
        repeat (20) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (6) @(negedge clock_i);
        check("cfg low", {8'h00, cfl}, {8'h00, init(16'h1FFD)});
        check("bandgap", {8'h00, bg}, {8'h00, init(16'h1FFB)});
        check("aux two", {8'h00, aux}, 16'h0006);
        sfr_wr(8'hF6, 8'hC3);
        sfr_rd(8'hF6, 8'hC3);
        check("cfg low sw", {8'h00, cfl}, 16'h00C3);
        sfr_wr(8'hF5, 8'h3C);
        sfr_rd(8'hF5, 8'h3C);
        check("bandgap sw", {8'h00, bg}, 16'h003C);
        sfr_rd(8'hC9, 8'h00);
        sfr_rd(8'h97, 8'h00);
        sfr_rd(8'h80, 8'h00);
        xchk(16'h1F00, 8'h5A, 0);
        sfr_wr(8'hC9, 8'h47);
        sfr_rd(8'hC9, 8'h80);
        xchk(16'h1F00, 8'h5A, W);
        crd(16'h1F00, 8'h5A);
        xchk(16'h0100, 8'h11, 0);
        xchk(16'h1FFD, 8'h22, 0);
        crd(16'h0100, init(16'h0100));
        sfr_wr(8'h97, 8'h65);
        sfr_rd(8'h97, 8'h01);
        xchk(16'h0000, 8'h33, W);
        xchk(16'h1EFF, 8'h44, W);
        xchk(16'h1FFD, 8'h55, W);
        xchk(16'h1FFF, 8'h66, 0);
        crd(16'h1EFF, 8'h44);
        crd(16'h1FFF, init(16'h1FFF));
        sfr_wr(8'h97, 8'h00);
        sfr_rd(8'h97, 8'h00);
        xchk(16'h0000, 8'h77, 0);
        crd(16'h0000, 8'h33);
        sfr_wr(8'hC9, 8'hE2);
        sfr_rd(8'hC9, 8'h20);
        xchk(16'h1F01, 8'h12, 0);
        xchk(16'hEE00, 8'hA5, E);
        lat = 8'hFF;
        sfr_wr(8'hC9, 8'h47);
        for (int s = 1; s < 4; s++)
        begin
            sfr_wr(8'hF7, 8'(s * 2));
            xchk(16'h1F02, 8'h99, (s == 1) ? T1 : (s == 2) ? T2 : T3);
            sfr_rd(8'hC9, 8'hC0);
            sfr_wr(8'hC9, 8'h00);
            sfr_rd(8'hC9, 8'h00);
            sfr_wr(8'hC9, 8'h47);
        end
        sfr_wr(8'hF7, 8'h00);
        lat = 8'd40;
        xchk(16'h1F03, 8'h5C, 40);
        sfr_rd(8'hC9, 8'h80);
        crd(16'h1F03, 8'h5C);
        sfr_wr(8'hC9, 8'h00);
        @(negedge clock_i);
        nrst_i = 1'b0;
        repeat (3) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (6) @(negedge clock_i);
        check("cfg reload", {8'h00, cfl}, 16'h0055);
        check("bandgap reload", {8'h00, bg}, {8'h00, init(16'h1FFB)});
        check("aux reload", {8'h00, aux}, 16'h0006);
        sfr_rd(8'hF6, 8'h55);
        sfr_rd(8'hC9, 8'h00);
        sfr_rd(8'h97, 8'h00);
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        end_of_test();
    end
endmodule : testbench
